// ### rtl/bst_link_if.sv
/*
  Interface carrying the four test pins between controller and device.
  TDO is a three-state pin expressed as value and enable.
*/
`timescale 1ns/1ns
interface bst_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;

  modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
  modport ctl (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface

// ### rtl/bst_pkg.sv
/*
  Package for the boundary-scan test access port: TAP states, instruction
  codes, register widths and reset values shared by both ends.
  Assumes a single core clock that oversamples the test clock.
*/
package bst_pkg;

  typedef enum logic [3:0] {
    BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR, BST_PA_DR, BST_EX2_DR, BST_UPD_DR,
    BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR, BST_PA_IR, BST_EX2_IR, BST_UPD_IR
  } bst_state_type;

  localparam int unsigned BST_IR_W       = 3;
  localparam int unsigned BST_ID_W       = 32;
  localparam int unsigned BST_BSR_W      = 16;
  localparam int unsigned BST_IN_W       = 8;
  localparam int unsigned BST_OUT_W      = 7;
  localparam int unsigned BST_OE_CELL    = 15;
  localparam int unsigned BST_RESET_TMS  = 5;

  localparam logic [2:0]  BST_I_EXTEST   = 3'h0;
  localparam logic [2:0]  BST_I_IDCODE   = 3'h1;
  localparam logic [2:0]  BST_I_SAMPLE_Z = 3'h2;
  localparam logic [2:0]  BST_I_SAMPLE   = 3'h4;
  localparam logic [2:0]  BST_I_BYPASS   = 3'h7;
  localparam logic [1:0]  BST_IR_CAPTURE = 2'h1;

  // Identification value is arbitrary.
  localparam logic [31:0] BST_IDCODE_VAL = 32'h0A5A_5001;
  localparam logic [15:0] BST_BSR_RESET  = 16'h8000;

  localparam int unsigned BST_TCK_HALF   = 4;

endpackage

// ### rtl/bst_tap_ctl.sv
/*
  Controller end of the boundary-scan link. Runs one scan of the IR or DR
  on request, making the test clock by division of core_clk.
  Assumes the user holds request data steady while busy.
*/
`timescale 1ns/1ns
module bst_tap_ctl
  import bst_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rstn,
  bst_link_if.ctl           link,
  input  wire logic         req_valid,
  output logic              req_ready,
  input  wire logic         req_ir,
  input  wire logic         req_reset,
  input  wire logic [5:0]   req_len,
  input  wire logic [31:0]  req_data,
  output logic              rsp_valid,
  output logic      [31:0]  rsp_data
);
  import bst_pkg::*;

  // ==========================================================
  // Test clock divider; TCK stays low while idle.
  typedef enum logic [2:0] {CTL_IDLE, CTL_RESET, CTL_HEAD, CTL_SHIFT, CTL_TAIL} bst_ctl_type;

  bst_ctl_type state_reg;
  logic [2:0]  div_reg;
  logic        tck_reg;
  logic        tms_reg;
  logic        tdi_reg;
  logic [5:0]  cnt_reg;
  logic [31:0] sh_reg;
  logic [1:0]  tdo_s_reg;
  logic        rise;
  logic        fall;
  logic [5:0]  sel_cnt;

  assign rise = (state_reg != CTL_IDLE) && !tck_reg && (div_reg == 3'(BST_TCK_HALF - 1));
  assign fall = tck_reg && (div_reg == 3'(BST_TCK_HALF - 1));
  assign sel_cnt = req_ir ? 6'h4 : 6'h3;
  assign req_ready = (state_reg == CTL_IDLE);
  assign link.tck = tck_reg;
  assign link.tms = tms_reg;
  assign link.tdi = tdi_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg   <= 3'h0;
      tck_reg   <= 1'b0;
      tdo_s_reg <= 2'h0;
    end else begin
      tdo_s_reg <= {tdo_s_reg[0], link.tdo};
      if (rise || fall) begin
        div_reg <= 3'h0;
        tck_reg <= ~tck_reg;
      end else if (state_reg != CTL_IDLE || tck_reg) begin
        div_reg <= div_reg + 3'h1;
      end
    end
  end

  // ==========================================================
  // Sequencer; TMS and TDI change on the falling edge, except TMS going high in CTL_IDLE when a request is taken.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= CTL_IDLE;
      tms_reg   <= 1'b1;
      tdi_reg   <= 1'b1;
      cnt_reg   <= 6'h0;
      sh_reg    <= 32'h0;
      rsp_valid <= 1'b0;
      rsp_data  <= 32'h0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state_reg)
        CTL_IDLE: begin
          if (req_valid) begin
            sh_reg <= req_data;
            if (req_reset) begin
              state_reg <= CTL_RESET;
              tms_reg   <= 1'b1;
              cnt_reg   <= 6'(BST_RESET_TMS);
            end else begin
              // From Run-Test/Idle: 1,0,0 to Shift-DR; 1,1,0,0 to Shift-IR.
              state_reg <= CTL_HEAD;
              tms_reg   <= 1'b1;
              cnt_reg   <= sel_cnt;
            end
          end
        end
        CTL_RESET: begin
          if (fall) begin
            cnt_reg <= cnt_reg - 6'h1;
            if (cnt_reg == 6'h1) begin
              tms_reg   <= 1'b0;
              state_reg <= CTL_TAIL;
              cnt_reg   <= 6'h1;
            end
          end
        end
        CTL_HEAD: begin
          if (fall) begin
            cnt_reg <= cnt_reg - 6'h1;
            tms_reg <= (req_ir && cnt_reg == 6'h4);
            if (cnt_reg == 6'h1) begin
              state_reg <= CTL_SHIFT;
              cnt_reg   <= req_len;
              tdi_reg   <= sh_reg[0];
              tms_reg   <= (req_len == 6'h1);
            end
          end
        end
        CTL_SHIFT: begin
          // TDO is taken just before the falling edge, because the device output and its
          // trip back through the synchroniser lag the falling edge by more than a half period.
          if (fall) begin
            sh_reg  <= {tdo_s_reg[1], sh_reg[31:1]};
            cnt_reg <= cnt_reg - 6'h1;
            tdi_reg <= sh_reg[1];
            tms_reg <= (cnt_reg == 6'h2);
            if (cnt_reg == 6'h1) begin
              // Exit1 then Update then Run-Test/Idle.
              state_reg <= CTL_TAIL;
              tms_reg   <= 1'b1;
              cnt_reg   <= 6'h2;
            end
          end
        end
        CTL_TAIL: begin
          if (fall) begin
            cnt_reg <= cnt_reg - 6'h1;
            tms_reg <= 1'b0;
            if (cnt_reg == 6'h1) begin
              state_reg <= CTL_IDLE;
              rsp_valid <= 1'b1;
              rsp_data  <= sh_reg >> (6'd32 - req_len);
            end
          end
        end
        default: state_reg <= CTL_IDLE;
      endcase
    end
  end

endmodule

// ### rtl/bst_tap_dev.sv
/*
  Device end of the boundary-scan test access port.
  Assumes core_clk runs far faster than the test clock; all pins are
  synchronised and test clock edges are found by sampling.
*/
// Functional notes
// - Sample on TCK rise, drive on fall
// - TMS pulled high, read at rise
// - TDI enters MSB, TDO from LSB
// - TDO driven only in shift states
// - Five TMS-high edges reset the TAP
// - Power-up reset leaves TDO high-Z
// - One data register selected by instruction
// - Three-bit instruction register shifted serially
// - IDCODE current after reset
// - Capture-IR loads binary 01 low
// - One-bit bypass cleared under BYPASS
// - Boundary cells capture pins, shift in Shift-DR
// - Capture under EXTEST, SAMPLE, SAMPLE Z
// - Hardwired 32-bit ID captured, shifted
// - Controller avoids three reserved codes; the bench still loads code 3, which the device treats as bypass
// - Instruction takes effect at Update-IR
// - EXTEST drives preloaded cells onto outputs
// - SAMPLE Z forces outputs high-Z
// - Idle board holds TCK low
// - SAMPLE captures pins, shift preloads
// - BYPASS puts bypass on path
// - Enable cell gates outputs, preset high
`timescale 1ns/1ns
module bst_tap_dev
  import bst_pkg::*;
(
  input  wire logic                           core_clk,
  input  wire logic                           rstn,
  bst_link_if.dev                             link,
  input  wire logic [bst_pkg::BST_IN_W-1:0]   pin_in,
  input  wire logic [bst_pkg::BST_OUT_W-1:0]  core_out,
  output logic      [bst_pkg::BST_OUT_W-1:0]  pin_out,
  output logic                                pin_oe,
  output logic                                test_mode
);
  import bst_pkg::*;

  // ==========================================================
  // Pin synchronisers and test clock edge detection.
  logic [2:0] tck_s_reg;
  logic [1:0] tms_s_reg;
  logic [1:0] tdi_s_reg;
  logic       tck_rise;
  logic       tck_fall;
  logic       tms_v;
  logic       tdi_v;
  logic [BST_IN_W-1:0] pin_s1_reg;
  logic [BST_IN_W-1:0] pin_s2_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tck_s_reg  <= 3'h0;
      tms_s_reg  <= 2'h3;
      tdi_s_reg  <= 2'h3;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      tck_s_reg  <= {tck_s_reg[1:0], link.tck};
      tms_s_reg  <= {tms_s_reg[0], link.tms};
      tdi_s_reg  <= {tdi_s_reg[0], link.tdi};
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign tck_rise = tck_s_reg[1] & ~tck_s_reg[2];
  assign tck_fall = ~tck_s_reg[1] & tck_s_reg[2];
  // An unknown or floating TMS reads high, as with a pull-up.
  assign tms_v    = (tms_s_reg[1] !== 1'b0);
  assign tdi_v    = (tdi_s_reg[1] !== 1'b0);

  // ==========================================================
  // TAP state machine.
  bst_state_type state_reg;
  bst_state_type state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BST_TLR:    state_next = tms_v ? BST_TLR    : BST_RTI;
      BST_RTI:    state_next = tms_v ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR: state_next = tms_v ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: state_next = tms_v ? BST_EX1_DR : BST_SH_DR;
      BST_SH_DR:  state_next = tms_v ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR: state_next = tms_v ? BST_UPD_DR : BST_PA_DR;
      BST_PA_DR:  state_next = tms_v ? BST_EX2_DR : BST_PA_DR;
      BST_EX2_DR: state_next = tms_v ? BST_UPD_DR : BST_SH_DR;
      BST_UPD_DR: state_next = tms_v ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR: state_next = tms_v ? BST_TLR    : BST_CAP_IR;
      BST_CAP_IR: state_next = tms_v ? BST_EX1_IR : BST_SH_IR;
      BST_SH_IR:  state_next = tms_v ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR: state_next = tms_v ? BST_UPD_IR : BST_PA_IR;
      BST_PA_IR:  state_next = tms_v ? BST_EX2_IR : BST_PA_IR;
      BST_EX2_IR: state_next = tms_v ? BST_UPD_IR : BST_SH_IR;
      BST_UPD_IR: state_next = tms_v ? BST_SEL_DR : BST_RTI;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= BST_TLR;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Instruction register and decode.
  logic [BST_IR_W-1:0] ir_sh_reg;
  logic [BST_IR_W-1:0] ir_reg;
  logic                sel_bsr;
  logic                sel_id;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ir_sh_reg <= BST_I_IDCODE;
    end else if (tck_rise) begin
      if (state_reg == BST_CAP_IR) begin
        ir_sh_reg <= {1'b0, BST_IR_CAPTURE};
      end else if (state_reg == BST_SH_IR) begin
        ir_sh_reg <= {tdi_v, ir_sh_reg[BST_IR_W-1:1]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ir_reg <= BST_I_IDCODE;
    end else if (tck_rise) begin
      if (state_reg == BST_TLR) begin
        ir_reg <= BST_I_IDCODE;
      end else if (state_reg == BST_UPD_IR) begin
        ir_reg <= ir_sh_reg;
      end
    end
  end

  // Reserved codes fall through to the bypass path.
  assign sel_bsr = (ir_reg == BST_I_EXTEST) || (ir_reg == BST_I_SAMPLE)
                || (ir_reg == BST_I_SAMPLE_Z);
  assign sel_id  = (ir_reg == BST_I_IDCODE);

  // ==========================================================
  // Data registers.
  logic                 byp_reg;
  logic [BST_ID_W-1:0]  id_reg;
  logic [BST_BSR_W-1:0] bsr_reg;
  logic [BST_BSR_W-1:0] bsr_upd_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      byp_reg <= 1'b0;
    end else if (tck_rise) begin
      if (state_reg == BST_CAP_DR) begin
        byp_reg <= 1'b0;
      end else if (state_reg == BST_SH_DR && !sel_bsr && !sel_id) begin
        byp_reg <= tdi_v;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      id_reg <= BST_IDCODE_VAL;
    end else if (tck_rise && sel_id) begin
      if (state_reg == BST_CAP_DR) begin
        id_reg <= BST_IDCODE_VAL;
      end else if (state_reg == BST_SH_DR) begin
        id_reg <= {tdi_v, id_reg[BST_ID_W-1:1]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bsr_reg <= BST_BSR_RESET;
    end else if (tck_rise && sel_bsr) begin
      if (state_reg == BST_CAP_DR) begin
        bsr_reg <= {bsr_upd_reg[BST_OE_CELL], pin_out, pin_s2_reg};
      end else if (state_reg == BST_SH_DR) begin
        bsr_reg <= {tdi_v, bsr_reg[BST_BSR_W-1:1]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bsr_upd_reg <= BST_BSR_RESET;
    end else if (tck_rise) begin
      if (state_reg == BST_TLR) begin
        bsr_upd_reg <= BST_BSR_RESET;
      end else if (state_reg == BST_UPD_DR && sel_bsr) begin
        bsr_upd_reg <= bsr_reg;
      end
    end
  end

  // ==========================================================
  // TDO updated on the falling test clock edge; pin control follows ir_reg on every core_clk.
  logic tdo_reg;
  logic tdo_oe_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_reg <= (state_reg == BST_SH_DR) || (state_reg == BST_SH_IR);
      if (state_reg == BST_SH_IR) begin
        tdo_reg <= ir_sh_reg[0];
      end else if (sel_bsr) begin
        tdo_reg <= bsr_reg[0];
      end else if (sel_id) begin
        tdo_reg <= id_reg[0];
      end else begin
        tdo_reg <= byp_reg;
      end
    end
  end

  assign link.tdo    = tdo_reg;
  assign link.tdo_oe = tdo_oe_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_out <= '0;
      pin_oe  <= 1'b1;
    end else begin
      unique case (ir_reg)
        BST_I_EXTEST: begin
          pin_out <= bsr_upd_reg[BST_IN_W +: BST_OUT_W];
          pin_oe  <= bsr_upd_reg[BST_OE_CELL];
        end
        BST_I_SAMPLE_Z: begin
          pin_out <= core_out;
          pin_oe  <= 1'b0;
        end
        default: begin
          pin_out <= core_out;
          pin_oe  <= 1'b1;
        end
      endcase
    end
  end

  assign test_mode = (ir_reg == BST_I_EXTEST);

endmodule

// ### testbench/boundary_scan_tap_test.sv
/*
  Self-checking bench joining the controller end and the device end.
  Assumes a 10 MHz core clock; the controller makes the test clock.
*/
`timescale 1ns/1ns
module boundary_scan_tap_test;
  import bst_pkg::*;
  typedef struct packed {
    logic        ir;
    logic        rst;
    logic [5:0]  len;
    logic [31:0] data;
    logic [31:0] mask;
    logic [31:0] exp;
    logic        oe;
    logic        tm;
    logic [6:0]  po;
  } bst_row_type;

  logic        core_clk;
  logic        rstn;
  logic [7:0]  pin_in;
  logic [6:0]  core_out;
  logic [6:0]  pin_out;
  logic        pin_oe;
  logic        test_mode;
  logic        req_valid;
  logic        req_ready;
  logic        req_ir;
  logic        req_reset;
  logic [5:0]  req_len;
  logic [31:0] req_data;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  logic [31:0] got;
  int          n_errors;
  int          comparisons;
  bst_row_type rows [11];

  bst_link_if u_bst_link_if ();
  bst_tap_dev u_bst_tap_dev (.core_clk(core_clk), .rstn(rstn), .link(u_bst_link_if), .pin_in(pin_in),
    .core_out(core_out), .pin_out(pin_out), .pin_oe(pin_oe), .test_mode(test_mode));
  bst_tap_ctl u_bst_tap_ctl (.core_clk(core_clk), .rstn(rstn), .link(u_bst_link_if), .req_valid(req_valid),
    .req_ready(req_ready), .req_ir(req_ir), .req_reset(req_reset), .req_len(req_len), .req_data(req_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  bst_tap_assertions u_bst_tap_assertions (.core_clk(core_clk), .rstn(rstn), .tck(u_bst_link_if.tck),
    .tms(u_bst_link_if.tms), .tdi(u_bst_link_if.tdi), .tdo(u_bst_link_if.tdo), .tdo_oe(u_bst_link_if.tdo_oe));

  // ==========================================================================
  // Tasks.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic scan(input bst_row_type r, output logic [31:0] res);
    int n;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_ir <= r.ir;
    req_reset <= r.rst;
    req_len <= r.len;
    req_data <= r.data;
    @(posedge core_clk);
    req_valid <= 1'b0;
    n = 0;
    @(negedge core_clk);
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 3000) begin
      n_errors++;
      complete_run();
    end
    res = rsp_data;
    repeat (8) @(negedge core_clk);
    check("tck", {31'h0, u_bst_link_if.tck}, 32'h0);
  endtask

  task automatic run_row(input bst_row_type r, input logic [7:0] pv);
    logic [31:0] e;
    @(posedge core_clk);
    pin_in <= pv;
    scan(r, got);
    e = (r.mask == 32'hFF) ? {24'h0, pv} : r.exp;
    check("rsp_data", got & r.mask, e & r.mask);
    check("pin_oe", {31'h0, pin_oe}, {31'h0, r.oe});
    check("test_mode", {31'h0, test_mode}, {31'h0, r.tm});
    check("pin_out", {25'h0, pin_out}, {25'h0, r.po});
  endtask

  // ==========================================================================
  // Clock and main sequence.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_ir = 1'b0;
    req_reset = 1'b0;
    req_len = 6'h01;
    req_data = 32'h0;
    pin_in = 8'h00;
    core_out = 7'h3C;
    n_errors = 0;
    comparisons = 0;
    rows = '{'{1'b0, 1'b1, 6'h01, 32'h0, 32'h0, 32'h0, 1'b1, 1'b0, 7'h3C},
      '{1'b0, 1'b0, 6'h20, 32'h0, 32'hFFFF_FFFF, BST_IDCODE_VAL, 1'b1, 1'b0, 7'h3C},
      '{1'b1, 1'b0, 6'h03, 32'h7, 32'h3, 32'h1, 1'b1, 1'b0, 7'h3C},
      '{1'b0, 1'b0, 6'h02, 32'h3, 32'h3, 32'h2, 1'b1, 1'b0, 7'h3C},
      '{1'b1, 1'b0, 6'h03, 32'h3, 32'h3, 32'h1, 1'b1, 1'b0, 7'h3C},
      '{1'b0, 1'b0, 6'h02, 32'h3, 32'h3, 32'h2, 1'b1, 1'b0, 7'h3C},
      '{1'b1, 1'b0, 6'h03, 32'h2, 32'h3, 32'h1, 1'b0, 1'b0, 7'h3C},
      '{1'b1, 1'b0, 6'h03, 32'h4, 32'h3, 32'h1, 1'b1, 1'b0, 7'h3C},
      '{1'b0, 1'b0, 6'h10, 32'hD500, 32'hFF, 32'h0, 1'b1, 1'b0, 7'h3C},
      '{1'b1, 1'b0, 6'h03, 32'h0, 32'h3, 32'h1, 1'b1, 1'b1, 7'h55},
      '{1'b0, 1'b0, 6'h10, 32'h2A00, 32'hFF, 32'h0, 1'b0, 1'b1, 7'h2A}};
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    check("tdo_oe", {31'h0, u_bst_link_if.tdo_oe}, 32'h0);
    for (int i = 0; i < 11; i++) begin
      run_row(rows[i], 8'hA5 ^ 8'(i));
    end
    @(posedge core_clk);
    rstn <= 1'b0;
    @(negedge core_clk);
    check("tdo_oe", {31'h0, u_bst_link_if.tdo_oe}, 32'h0);
    check("pin_oe", {31'h0, pin_oe}, 32'h1);
    check("test_mode", {31'h0, test_mode}, 32'h0);
    @(posedge core_clk);
    rstn <= 1'b1;
    run_row(rows[0], 8'h3C);
    run_row(rows[1], 8'h3C);
    scan(rows[9], got);
    check("pin_out", {25'h0, pin_out}, {25'h0, BST_BSR_RESET[14:8]});
    check("pin_oe", {31'h0, pin_oe}, {31'h0, BST_BSR_RESET[BST_OE_CELL]});
    run_row(rows[0], 8'h96);
    run_row(rows[1], 8'h96);
    complete_run();
  end
endmodule

// ### testbench/bst_tap_assertions.sv
/*
  Checker for the test link between the controller end and the device end.
  Assumes the test clock is sampled by core_clk and both ends share rstn.
*/
`timescale 1ns/1ns
module bst_tap_assertions
  import bst_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // ==========================================================================
  // Helper model of the TAP states, advanced on each sampled test clock rise.
  logic          tck_reg;
  logic          rise;
  bst_state_type st_reg;
  bst_state_type last_reg;
  bst_state_type st_next;
  logic [5:0]    bit_reg;
  logic          id_reg;
  logic [2:0]    ones_reg;

  assign rise = tck && !tck_reg;

  always_comb begin
    case (st_reg)
      BST_TLR:                         st_next = tms ? BST_TLR : BST_RTI;
      BST_RTI, BST_UPD_DR, BST_UPD_IR: st_next = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR:                      st_next = tms ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR, BST_SH_DR:           st_next = tms ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR:                      st_next = tms ? BST_UPD_DR : BST_PA_DR;
      BST_PA_DR:                       st_next = tms ? BST_EX2_DR : BST_PA_DR;
      BST_EX2_DR:                      st_next = tms ? BST_UPD_DR : BST_SH_DR;
      BST_SEL_IR:                      st_next = tms ? BST_TLR : BST_CAP_IR;
      BST_CAP_IR, BST_SH_IR:           st_next = tms ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR:                      st_next = tms ? BST_UPD_IR : BST_PA_IR;
      BST_PA_IR:                       st_next = tms ? BST_EX2_IR : BST_PA_IR;
      default:                         st_next = tms ? BST_UPD_IR : BST_SH_IR;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tck_reg  <= 1'b0;
      st_reg   <= BST_TLR;
      last_reg <= BST_TLR;
    end else begin
      tck_reg <= tck;
      if (rise) begin
        st_reg   <= st_next;
        last_reg <= st_reg;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_reg  <= 6'h00;
      id_reg   <= 1'b1;
      ones_reg <= 3'h0;
    end else if (rise) begin
      bit_reg  <= (st_reg == BST_SH_DR || st_reg == BST_SH_IR) ? bit_reg + 6'h01 : 6'h00;
      id_reg   <= (st_reg == BST_TLR) ? 1'b1 : ((st_reg == BST_UPD_IR) ? 1'b0 : id_reg);
      ones_reg <= !tms ? 3'h0 : ((ones_reg == 3'h7) ? ones_reg : ones_reg + 3'h1);
    end
  end

  // ==========================================================================
  // Assertions on the link.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_tck_half; $rose(tck) |-> ##1 tck [*3] ##1 !tck; endproperty
  a_tck_half: assert property (p_tck_half) else $error("test clock high time wrong");
  property p_tms_low; $changed(tms) |-> !tck; endproperty
  a_tms_low: assert property (p_tms_low) else $error("tms moved while tck high");
  property p_tdi_low; $changed(tdi) |-> !tck; endproperty
  a_tdi_low: assert property (p_tdi_low) else $error("tdi moved while tck high");
  property p_tdo_fall; tdo_oe && $changed(tdo) |-> !tck; endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved while tck high");
  property p_oe_fall; $changed(tdo_oe) |-> !tck; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved while tck high");
  property p_oe_shift;
    tdo_oe |-> (st_reg inside {BST_SH_DR, BST_SH_IR}) || (last_reg inside {BST_SH_DR, BST_SH_IR});
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("tdo driven outside shift");
  property p_ir_cap; rise && st_reg == BST_SH_IR && bit_reg < 6'h02 |-> tdo == (bit_reg == 6'h00); endproperty
  a_ir_cap: assert property (p_ir_cap) else $error("instruction capture bits wrong");
  property p_id; rise && st_reg == BST_SH_DR && id_reg && bit_reg < 6'h20 |-> tdo == BST_IDCODE_VAL[bit_reg[4:0]];
  endproperty
  a_id: assert property (p_id) else $error("identification bit wrong");
  property p_five; ones_reg >= 3'h5 |-> !tdo_oe; endproperty
  a_five: assert property (p_five) else $error("tdo driven after tms reset");

  c_ir_shift: cover property (rise && st_reg == BST_SH_IR);
  c_id_shift: cover property (rise && st_reg == BST_SH_DR && id_reg);
  c_five:     cover property (ones_reg == 3'h5);
endmodule
